// ==== lpmc_defs.vh ====
`ifndef LPMC_DEFS_VH
`define LPMC_DEFS_VH

// register byte offsets
`define LPMC_OFF_CTRL 12'h000
`define LPMC_OFF_STAT 12'h004
`define LPMC_OFF_IRQ_STAT 12'h008
`define LPMC_OFF_IRQ_MASK 12'h00c
`define LPMC_OFF_WAKE_EN 12'h010

// control fields
`define LPMC_CTRL_MODE_LSB 0
`define LPMC_CTRL_LPREG_BIT 2
`define LPMC_CTRL_ENTER_BIT 3
`define LPMC_CTRL_RESET 32'h0000_0000

// requested mode encoding
`define LPMC_MODE_SLEEP 2'h1
`define LPMC_MODE_STOP 2'h2
`define LPMC_MODE_STANDBY 2'h3

// boot source encoding
`define LPMC_BOOT_FLASH 2'h0
`define LPMC_BOOT_SYSMEM 2'h1
`define LPMC_BOOT_SRAM 2'h2

// regulator operation encoding
`define LPMC_REG_MAIN 2'h0
`define LPMC_REG_LOWPWR 2'h1
`define LPMC_REG_OFF 2'h2

// interrupt status bits
`define LPMC_IRQ_SLEEP_WAKE 0
`define LPMC_IRQ_STOP_WAKE 1
`define LPMC_IRQ_STANDBY_EXIT 2
`define LPMC_IRQ_WIDTH 3

// timing
`define LPMC_RESET_HOLD_NS 200
`define LPMC_CLK_NS 20
`define LPMC_RESET_HOLD_CYC ((`LPMC_RESET_HOLD_NS + `LPMC_CLK_NS - 1) / `LPMC_CLK_NS)

`endif

// ==== lpmc_sync.v ====
`timescale 1ns/10ps
`include "lpmc_defs.vh"

// two-flop synchroniser for pins arriving from outside the clock domain
module lpmc_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input wire hclk,
    input wire hresetn,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_ff;
reg [WIDTH-1:0] sync_ff;

// first stage feeds only the second stage
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        meta_ff <= RESET_VAL;
        sync_ff <= RESET_VAL;
    end else begin
        meta_ff <= async_in;
        sync_ff <= meta_ff;
    end
end

assign sync_out = sync_ff;

endmodule

// ==== lpmc_boot_sel.v ====
`timescale 1ns/10ps
`include "lpmc_defs.vh"

// latches the boot source once per reset sequence
module lpmc_boot_sel (
    input wire hclk,
    input wire hresetn,
    input wire sample,
    input wire boot_select_pin,
    input wire boot_select_option,
    output wire [1:0] boot_src,
    output wire boot_valid
);

reg [1:0] boot_src_ff;
reg boot_valid_ff;
reg [1:0] nxt_boot_src;

// pin low: user flash; pin high: option picks system memory or sram
always @* begin
    if (!boot_select_pin) begin
        nxt_boot_src = `LPMC_BOOT_FLASH;
    end else if (!boot_select_option) begin
        nxt_boot_src = `LPMC_BOOT_SYSMEM;
    end else begin
        nxt_boot_src = `LPMC_BOOT_SRAM;
    end
end

// strap is caught by a clocked sample after release, never by reset
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        boot_src_ff <= `LPMC_BOOT_FLASH;
        boot_valid_ff <= 1'b0;
    end else if (sample) begin
        boot_src_ff <= nxt_boot_src;
        boot_valid_ff <= 1'b1;
    end
end

assign boot_src = boot_src_ff;
assign boot_valid = boot_valid_ff;

endmodule

// ==== lpmc_top.v ====
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "lpmc_defs.vh"

module lpmc_top #(
    parameter NUM_LINES = 16,
    parameter NUM_PERIPH = 8
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    output wire irq,
    input wire core_sleep_req,
    input wire [NUM_PERIPH-1:0] periph_irq,
    input wire [NUM_LINES-1:0] external_event_lines,
    input wire supply_threshold_detector,
    input wire usb_wakeup,
    input wire rtc_alarm,
    input wire [1:0] comparator_outputs,
    input wire i2c_wakeup,
    input wire usart_wakeup,
    input wire reset_pin_low,
    input wire independent_watchdog,
    input wire wakeup_pin,
    input wire boot_select_pin,
    input wire boot_select_option,
    output wire core_clk_en,
    output wire periph_clk_en,
    output wire pll_en,
    output wire internal_fast_rc_osc_en,
    output wire crystal_osc_en,
    output wire [1:0] regulator_mode,
    output wire regulator_out_oe_n,
    output wire core_power_en,
    output wire retain_en,
    output wire core_reset_n,
    output wire [1:0] boot_src,
    output wire rtc_keep_alive,
    output wire watchdog_keep_alive
);

////////////////////////////////////////////////////////////////////////////////
// state encoding
localparam [2:0] ST_BOOT = 3'h0;
localparam [2:0] ST_RUN = 3'h1;
localparam [2:0] ST_SLEEP = 3'h2;
localparam [2:0] ST_STOP = 3'h3;
localparam [2:0] ST_STANDBY = 3'h4;
// hold length worked out as a full integer, then cut to the counter width
localparam integer HOLD_FULL = `LPMC_RESET_HOLD_CYC;
localparam [7:0] HOLD_CYC = HOLD_FULL[7:0];

reg [2:0] state_ff;
reg [2:0] nxt_state;
reg [7:0] hold_cnt_ff;
reg [7:0] nxt_hold_cnt;
reg [31:0] ctrl_ff;
reg [`LPMC_IRQ_WIDTH-1:0] irq_stat_ff;
reg [`LPMC_IRQ_WIDTH-1:0] irq_mask_ff;
reg [NUM_LINES-1:0] wake_en_ff;
reg stop_lpreg_ff;
reg wk_pin_d_ff;
reg [`LPMC_IRQ_WIDTH-1:0] ev_set;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers: every off-domain input passes two flops
localparam SYNC_W = NUM_LINES + 7 + NUM_PERIPH;
wire [SYNC_W-1:0] raw_pins;
wire [SYNC_W-1:0] pins_s;

assign raw_pins = {periph_irq, usart_wakeup, i2c_wakeup, comparator_outputs, usb_wakeup,
    supply_threshold_detector, rtc_alarm, external_event_lines};

lpmc_sync #(.WIDTH(SYNC_W), .RESET_VAL({SYNC_W{1'b0}})) u_sync_ev (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(raw_pins),
    .sync_out(pins_s)
);

// reset pin idles high, so reset value is one
wire [2:0] ctl_s;
lpmc_sync #(.WIDTH(3), .RESET_VAL(3'h4)) u_sync_ctl (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({reset_pin_low, independent_watchdog, wakeup_pin}),
    .sync_out(ctl_s)
);

// straps are pins too; they settle long before the boot hold ends
wire [1:0] strap_s;
lpmc_sync #(.WIDTH(2), .RESET_VAL(2'h0)) u_sync_strap (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({boot_select_pin, boot_select_option}),
    .sync_out(strap_s)
);

wire [NUM_LINES-1:0] lines_s = pins_s[NUM_LINES-1:0];
wire rtc_alarm_s = pins_s[NUM_LINES];
wire other_ev_s = |pins_s[NUM_LINES+6:NUM_LINES+1];
wire periph_ev_s = |pins_s[SYNC_W-1:NUM_LINES+7];
wire rst_pin_s = ctl_s[2];
wire wdg_s = ctl_s[1];
wire wk_pin_s = ctl_s[0];

////////////////////////////////////////////////////////////////////////////////
// wakeup conditions
wire wk_rise = wk_pin_s & ~wk_pin_d_ff;
wire stop_wake = (|(lines_s & wake_en_ff)) | rtc_alarm_s | other_ev_s;
// stop sources also wake sleep, since peripherals keep their clocks there
wire sleep_wake = periph_ev_s | stop_wake;
wire standby_exit = ~rst_pin_s | wdg_s | wk_rise | rtc_alarm_s;

// software request captured from the control register
wire enter_req = ctrl_ff[`LPMC_CTRL_ENTER_BIT] & core_sleep_req;
wire [1:0] req_mode = ctrl_ff[`LPMC_CTRL_MODE_LSB+1:`LPMC_CTRL_MODE_LSB];

// wakeup pin edge detect on the synchronised level
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wk_pin_d_ff <= 1'b0;
    end else begin
        wk_pin_d_ff <= wk_pin_s;
    end
end

////////////////////////////////////////////////////////////////////////////////
// mode sequencer
always @* begin
    nxt_state = state_ff;
    nxt_hold_cnt = hold_cnt_ff;
    ev_set = {`LPMC_IRQ_WIDTH{1'b0}};
    case (state_ff)
        ST_BOOT: begin
            // hold core in reset, then run from the sampled boot source
            if (hold_cnt_ff == 8'h00) begin
                nxt_state = ST_RUN;
            end else begin
                nxt_hold_cnt = hold_cnt_ff - 8'h01;
            end
        end
        ST_RUN: begin
            // mode zero with enter set is refused: state stays in run
            if (enter_req) begin
                case (req_mode)
                    `LPMC_MODE_SLEEP: nxt_state = ST_SLEEP;
                    `LPMC_MODE_STOP: nxt_state = ST_STOP;
                    `LPMC_MODE_STANDBY: nxt_state = ST_STANDBY;
                    default: nxt_state = ST_RUN;
                endcase
            end
        end
        ST_SLEEP: begin
            if (sleep_wake) begin
                nxt_state = ST_RUN;
                ev_set[`LPMC_IRQ_SLEEP_WAKE] = 1'b1;
            end
        end
        ST_STOP: begin
            // registers are never reset here, so contents survive
            if (stop_wake) begin
                nxt_state = ST_RUN;
                ev_set[`LPMC_IRQ_STOP_WAKE] = 1'b1;
            end
        end
        ST_STANDBY: begin
            if (standby_exit) begin
                nxt_state = ST_BOOT;
                nxt_hold_cnt = HOLD_CYC;
                ev_set[`LPMC_IRQ_STANDBY_EXIT] = 1'b1;
            end
        end
        default: begin
            nxt_state = ST_BOOT;
            nxt_hold_cnt = HOLD_CYC;
        end
    endcase
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        state_ff <= ST_BOOT;
        hold_cnt_ff <= HOLD_CYC;
    end else begin
        state_ff <= nxt_state;
        hold_cnt_ff <= nxt_hold_cnt;
    end
end

// regulator choice for stop is frozen at entry
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        stop_lpreg_ff <= 1'b0;
    end else if (state_ff == ST_RUN && nxt_state == ST_STOP) begin
        stop_lpreg_ff <= ctrl_ff[`LPMC_CTRL_LPREG_BIT];
    end
end

////////////////////////////////////////////////////////////////////////////////
// boot source selection, resampled on every pass through boot
// straps are caught on the last hold cycle, at the same edge that enters run
wire boot_sample = (state_ff == ST_BOOT) && (hold_cnt_ff == 8'h00);
wire boot_valid;
lpmc_boot_sel u_boot (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample(boot_sample),
    .boot_select_pin(strap_s[1]),
    .boot_select_option(strap_s[0]),
    .boot_src(boot_src),
    .boot_valid(boot_valid)
);

////////////////////////////////////////////////////////////////////////////////
// power and clock outputs
wire in_stop = (state_ff == ST_STOP);
wire in_stby = (state_ff == ST_STANDBY);

assign core_clk_en = (state_ff == ST_RUN);
assign periph_clk_en = ~in_stop & ~in_stby;
assign pll_en = ~in_stop & ~in_stby;
assign internal_fast_rc_osc_en = ~in_stop & ~in_stby;
assign crystal_osc_en = ~in_stop & ~in_stby;
// main after reset; low-power only in stop when chosen
assign regulator_mode = in_stby ? `LPMC_REG_OFF :
    (in_stop & stop_lpreg_ff) ? `LPMC_REG_LOWPWR : `LPMC_REG_MAIN;
assign regulator_out_oe_n = in_stby;
assign core_power_en = ~in_stby;
assign retain_en = in_stop;
assign core_reset_n = ~in_stby & (state_ff != ST_BOOT);
assign rtc_keep_alive = 1'b1;
assign watchdog_keep_alive = 1'b1;

////////////////////////////////////////////////////////////////////////////////
// ahb-lite slave: zero wait states, always okay
reg wr_pend_ff;
reg [11:0] addr_ff;
reg [31:0] rdata_ff;
reg [31:0] nxt_rdata;
wire acc = hsel & htrans[1] & hready;
wire wr_hit = wr_pend_ff;

// write data arrives one cycle behind its address phase
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_pend_ff <= 1'b0;
        addr_ff <= 12'h000;
    end else begin
        wr_pend_ff <= acc & hwrite;
        addr_ff <= haddr;
    end
end

// read data is registered at the address phase for the data phase
always @* begin
    case (haddr)
        `LPMC_OFF_CTRL: nxt_rdata = ctrl_ff;
        `LPMC_OFF_STAT: nxt_rdata = {26'h0, boot_valid, boot_src, state_ff};
        `LPMC_OFF_IRQ_STAT: nxt_rdata = {29'h0, irq_stat_ff};
        `LPMC_OFF_IRQ_MASK: nxt_rdata = {29'h0, irq_mask_ff};
        `LPMC_OFF_WAKE_EN: nxt_rdata = {{(32-NUM_LINES){1'b0}}, wake_en_ff};
        default: nxt_rdata = 32'h0000_0000;
    endcase
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        rdata_ff <= 32'h0000_0000;
    end else if (acc & ~hwrite) begin
        rdata_ff <= nxt_rdata;
    end
end

// control registers; the enter bit self-clears once acted on
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ctrl_ff <= `LPMC_CTRL_RESET;
        irq_mask_ff <= {`LPMC_IRQ_WIDTH{1'b0}};
        wake_en_ff <= {NUM_LINES{1'b1}};
    end else if (in_stby) begin
        // standby wipes core-domain state
        ctrl_ff <= `LPMC_CTRL_RESET;
        irq_mask_ff <= {`LPMC_IRQ_WIDTH{1'b0}};
        wake_en_ff <= {NUM_LINES{1'b1}};
    end else if (wr_hit) begin
        if (addr_ff == `LPMC_OFF_CTRL) begin
            ctrl_ff <= {28'h0, hwdata[3:0]};
        end
        if (addr_ff == `LPMC_OFF_IRQ_MASK) begin
            irq_mask_ff <= hwdata[`LPMC_IRQ_WIDTH-1:0];
        end
        if (addr_ff == `LPMC_OFF_WAKE_EN) begin
            wake_en_ff <= hwdata[NUM_LINES-1:0];
        end
    end else if (state_ff != ST_RUN) begin
        ctrl_ff[`LPMC_CTRL_ENTER_BIT] <= 1'b0;
    end
end

// sticky status, write one to clear; a new event wins over the clear
wire [`LPMC_IRQ_WIDTH-1:0] w1c = (wr_hit && addr_ff == `LPMC_OFF_IRQ_STAT) ?
    hwdata[`LPMC_IRQ_WIDTH-1:0] : {`LPMC_IRQ_WIDTH{1'b0}};

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        irq_stat_ff <= {`LPMC_IRQ_WIDTH{1'b0}};
    end else begin
        irq_stat_ff <= (irq_stat_ff & ~w1c) | ev_set;
    end
end

// level interrupt: any unmasked sticky bit
assign irq = |(irq_stat_ff & irq_mask_ff);
// one slave only: never stretches a transfer, never errors
assign hrdata = rdata_ff;
assign hreadyout = 1'b1;
assign hresp = 1'b0;

endmodule

// ==== lpmc_far_end.sv ====
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////
// core and wakeup sources: one source is raised per kick, for len cycles
module lpmc_far_end (
    input logic hclk,
    input logic want_sleep,
    input logic kick,
    input logic [3:0] sel,
    input logic [2:0] len,
    output logic core_sleep_req,
    output logic [15:0] wake
);
    logic sleep_ff = 1'b0;
    logic [2:0] cnt_ff = 3'h0;
    logic [3:0] sel_ff = 4'h0;

    // a long len plays a slow source; released lines fall back to idle
    always @(posedge hclk) begin
        sleep_ff <= want_sleep;
        if (kick) begin
            cnt_ff <= len;
            sel_ff <= sel;
        end else if (cnt_ff != 3'h0) begin
            cnt_ff <= cnt_ff - 3'h1;
        end
    end

    assign core_sleep_req = sleep_ff;
    assign wake = (cnt_ff != 3'h0) ? (16'h0001 << sel_ff) : 16'h0000;
endmodule

// ==== lpmc_properties.sv ====
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////
module lpmc_checks #(
    parameter NUM_LINES = 16,
    parameter NUM_PERIPH = 8
) (
    input logic hclk,
    input logic hresetn,
    input logic [NUM_PERIPH-1:0] periph_irq,
    input logic [NUM_LINES-1:0] external_event_lines,
    input logic rtc_alarm,
    input logic reset_pin_low,
    input logic independent_watchdog,
    input logic core_clk_en,
    input logic periph_clk_en,
    input logic pll_en,
    input logic internal_fast_rc_osc_en,
    input logic crystal_osc_en,
    input logic [1:0] regulator_mode,
    input logic regulator_out_oe_n,
    input logic core_power_en,
    input logic retain_en,
    input logic core_reset_n,
    input logic rtc_keep_alive,
    input logic watchdog_keep_alive
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_run;
        core_clk_en |-> core_reset_n && regulator_mode == 2'h0 && pll_en && !regulator_out_oe_n;
    endproperty
    property p_stop;
        retain_en |-> !(pll_en || internal_fast_rc_osc_en || crystal_osc_en || core_clk_en);
    endproperty
    property p_standby;
        regulator_out_oe_n |-> regulator_mode == 2'h2 && !core_power_en && !core_reset_n && !pll_en;
    endproperty
    property p_sleep;
        !core_clk_en && core_reset_n && !retain_en |-> periph_clk_en && pll_en;
    endproperty
    property p_alive;
        rtc_keep_alive && watchdog_keep_alive;
    endproperty
    // boot must hold the core in reset after every standby exit
    property p_exit;
        $fell(regulator_out_oe_n) |-> !core_reset_n [*8];
    endproperty
    // wake paths pass a two-flop sync, so allow a few edges
    property p_wake_sleep;
        !core_clk_en && periph_clk_en && core_reset_n && |periph_irq |-> ##[1:4] core_clk_en;
    endproperty
    property p_wake_stop;
        retain_en && |external_event_lines |-> ##[1:4] !retain_en;
    endproperty
    property p_wake_sb;
        regulator_out_oe_n && (rtc_alarm || independent_watchdog || !reset_pin_low)
            |-> ##[1:5] !regulator_out_oe_n;
    endproperty

    a_run: assert property (p_run) else $error("run outputs wrong");
    a_stop: assert property (p_stop) else $error("stop clocks on");
    a_standby: assert property (p_standby) else $error("standby power on");
    a_sleep: assert property (p_sleep) else $error("sleep stopped peripherals");
    a_alive: assert property (p_alive) else $error("keep alive dropped");
    a_exit: assert property (p_exit) else $error("standby exit skipped boot");
    a_wake_sleep: assert property (p_wake_sleep) else $error("sleep not woken");
    a_wake_stop: assert property (p_wake_stop) else $error("stop not woken");
    a_wake_sb: assert property (p_wake_sb) else $error("standby not left");

    c_sleep: cover property ($fell(core_clk_en) && periph_clk_en);
    c_stop: cover property ($rose(retain_en));
    c_standby: cover property ($rose(regulator_out_oe_n));
endmodule

bind lpmc_top lpmc_checks #(.NUM_LINES(NUM_LINES), .NUM_PERIPH(NUM_PERIPH)) i_checks (
    .hclk(hclk), .hresetn(hresetn), .periph_irq(periph_irq),
    .external_event_lines(external_event_lines), .rtc_alarm(rtc_alarm),
    .reset_pin_low(reset_pin_low), .independent_watchdog(independent_watchdog),
    .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en), .pll_en(pll_en),
    .internal_fast_rc_osc_en(internal_fast_rc_osc_en), .crystal_osc_en(crystal_osc_en),
    .regulator_mode(regulator_mode), .regulator_out_oe_n(regulator_out_oe_n),
    .core_power_en(core_power_en), .retain_en(retain_en), .core_reset_n(core_reset_n),
    .rtc_keep_alive(rtc_keep_alive), .watchdog_keep_alive(watchdog_keep_alive));

// ==== low_power_mode_controller_test.sv ====
`timescale 1ns/10ps
`include "lpmc_defs.vh"

module low_power_mode_controller_test;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic strap_pin = 1'b0;
    logic strap_opt = 1'b0;
    logic want = 1'b0;
    logic kick = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [2:0] len = 3'h4;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hreadyout, hresp, irq, core_sleep_req, core_clk_en, periph_clk_en, pll_en;
    logic rc_en, xtal_en, reg_oe_n, core_power_en, retain_en, core_reset_n, rtc_ka, wdg_ka;
    logic [1:0] regulator_mode, boot_src;
    logic [15:0] wake;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    always #10 hclk = ~hclk;

    ////////////////////////////////////////////////////////////////////
    lpmc_far_end i_far (.hclk(hclk), .want_sleep(want), .kick(kick), .sel(sel), .len(len),
        .core_sleep_req(core_sleep_req), .wake(wake));

    lpmc_top i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .core_sleep_req(core_sleep_req),
        .periph_irq({wake[13], 6'h00, wake[0]}),
        .external_event_lines({wake[2], 14'h0000, wake[1]}),
        .supply_threshold_detector(wake[3]), .usb_wakeup(wake[4]), .rtc_alarm(wake[5]),
        .comparator_outputs(wake[7:6]), .i2c_wakeup(wake[8]), .usart_wakeup(wake[9]),
        .reset_pin_low(~wake[10]), .independent_watchdog(wake[11]), .wakeup_pin(wake[12]),
        .boot_select_pin(strap_pin), .boot_select_option(strap_opt),
        .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en), .pll_en(pll_en),
        .internal_fast_rc_osc_en(rc_en), .crystal_osc_en(xtal_en),
        .regulator_mode(regulator_mode), .regulator_out_oe_n(reg_oe_n),
        .core_power_en(core_power_en), .retain_en(retain_en), .core_reset_n(core_reset_n),
        .boot_src(boot_src), .rtc_keep_alive(rtc_ka), .watchdog_keep_alive(wdg_ka));

    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // single word transfer; returns 1 ns past the data edge so outputs have settled
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        #1;
    endtask

    // quiet time after the kick lets the source fall before the next entry
    task automatic poke(input logic [3:0] s);
        @(posedge hclk);
        sel <= s;
        kick <= 1'b1;
        @(posedge hclk);
        kick <= 1'b0;
        repeat (12) @(posedge hclk);
        #1;
    endtask

    function automatic logic sig(input int k);
        case (k)
            0: return core_clk_en;
            1: return retain_en;
            2: return reg_oe_n;
            default: return core_reset_n;
        endcase
    endfunction

    task automatic wait_on(input int k, input logic v);
        int i;
        for (i = 0; i < 40 && sig(k) !== v; i++) begin
            @(posedge hclk);
            #1;
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        bus(1'b0, `LPMC_OFF_STAT, 32'h0);
        check("status", rd, 32'h21);
        bus(1'b0, `LPMC_OFF_WAKE_EN, 32'h0);
        check("wake enable", rd, 32'h0000_ffff);
        bus(1'b1, `LPMC_OFF_CTRL, 32'h8);
        bus(1'b0, `LPMC_OFF_STAT, 32'h0);
        check("mode zero refused", {rd[5:0], regulator_mode}, 32'h84);
        bus(1'b1, 12'h014, 32'hffff_ffff);
        bus(1'b0, 12'h014, 32'h0);
        check("unmapped", rd, 32'h0);
        check("okay", hresp, 32'h0);
    endtask

    task automatic t_sleep();
        int k;
        for (k = 0; k < 2; k++) begin
            bus(1'b1, `LPMC_OFF_CTRL, 32'h9);
            wait_on(0, 1'b0);
            check("sleep clocks", {periph_clk_en, pll_en, core_reset_n}, 32'h7);
            poke(k ? 4'hd : 4'h0);
            check("sleep wake", core_clk_en, 32'h1);
        end
    endtask

    task automatic t_stop();
        logic [4:0] s;
        for (s = 5'h1; s <= 5'h9; s++) begin
            bus(1'b1, `LPMC_OFF_CTRL, {28'h0, 1'b1, s[0], 2'h2});
            wait_on(1, 1'b1);
            check("stop clocks", {core_clk_en, pll_en, rc_en, xtal_en}, 32'h0);
            check("stop regulator", regulator_mode, {31'h0, s[0]});
            poke(s[3:0]);
            check("stop wake", {retain_en, core_clk_en, regulator_mode}, 32'h4);
            bus(1'b0, `LPMC_OFF_CTRL, 32'h0);
            check("stop kept ctrl", rd, {29'h0, s[0], 2'h2});
        end
        check("irq masked", irq, 32'h0);
        bus(1'b1, `LPMC_OFF_IRQ_MASK, 32'h2);
        check("irq raised", irq, 32'h1);
        bus(1'b1, `LPMC_OFF_IRQ_STAT, 32'h3);
        bus(1'b0, `LPMC_OFF_IRQ_STAT, 32'h0);
        check("irq stat cleared", rd, 32'h0);
        check("irq cleared", irq, 32'h0);
    endtask

    task automatic t_standby();
        int k;
        for (k = 0; k < 4; k++) begin
            @(posedge hclk);
            strap_pin <= (k != 2);
            strap_opt <= (k == 1);
            len <= 3'h7;
            bus(1'b1, `LPMC_OFF_IRQ_MASK, 32'h5);
            bus(1'b1, `LPMC_OFF_CTRL, 32'hb);
            wait_on(2, 1'b1);
            check("standby", {core_power_en, core_reset_n, pll_en, rc_en, xtal_en}, 32'h0);
            check("standby regulator", regulator_mode, 32'h2);
            poke(k == 3 ? 4'h5 : 4'ha + 4'(k));
            check("left standby", reg_oe_n, 32'h0);
            wait_on(3, 1'b1);
            check("boot source", boot_src, k == 2 ? 32'h0 : k == 1 ? 32'h2 : 32'h1);
            bus(1'b0, `LPMC_OFF_IRQ_MASK, 32'h0);
            check("mask lost", rd, 32'h0);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // hang guard, far above the roughly 400 cycles the tests need
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        want <= 1'b1;
        wait_on(3, 1'b1);
        check("boot", {boot_src, regulator_mode, reg_oe_n, core_power_en}, 32'h1);
        check("keep alive", {rtc_ka, wdg_ka}, 32'h3);
        t_regs();
        t_sleep();
        t_stop();
        t_standby();
        wrap_up();
    end
endmodule
